// >>> fsc_pkg.sv
// constants and link types for the flash self-write controller
// assumes a device that takes one register or table access at a time and answers with ack
package fsc_pkg;

    // timing: the long program/erase cycle stalls the device for about 2 ms
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint PROG_TIME_PS = 64'd2_000_000_000;
    localparam int PROG_CYCLES = int'(PROG_TIME_PS / CLK_PERIOD_PS);

    // geometry
    localparam int ROW_BYTES = 64;
    localparam int ROW_BITS = 6;
    localparam int BLOCK_BITS = 10;
    localparam int PTR_W = 22;

    // device control register fields
    localparam int CTL_ERASE_BIT = 4;
    localparam int CTL_ERROR_BIT = 3;
    localparam int CTL_WRITE_ENABLE_BIT_BIT = 2;
    localparam int CTL_START_BIT = 1;
    localparam int IRQ_GLOBAL_BIT = 7;
    localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_2 = 8'haa;

    // software register offsets (byte addresses)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_BUF_IDX = 8'h08;
    localparam logic [7:0] REG_BUF_DATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // command register fields
    localparam int CMD_PROGRAM_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_ERASE_FIRST_BIT = 2;
    localparam int CMD_VERIFY_BIT = 3;

    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_WERR_BIT = 2;
    localparam int ST_VFAIL_BIT = 3;
    localparam int ST_OVERRUN_BIT = 4;
    localparam int ST_ROW_LSB = 8;
    localparam int ST_CTL_LSB = 16;

    typedef enum logic [2:0] {
        FSC_OP_REG_WR,
        FSC_OP_REG_RD,
        FSC_OP_TBL_WR,
        FSC_OP_TBL_WR_INC,
        FSC_OP_TBL_RD_INC
    } fsc_op_t;

    typedef enum logic [2:0] {
        FSC_SEL_PTR_UPPER,
        FSC_SEL_PTR_HIGH,
        FSC_SEL_PTR_LOW,
        FSC_SEL_BYTE_LATCH,
        FSC_SEL_IRQ_CTL,
        FSC_SEL_UNLOCK_KEY,
        FSC_SEL_WRITE_CTL
    } fsc_sel_t;

    typedef struct packed {
        logic req;
        fsc_op_t op;
        fsc_sel_t sel;
        logic [7:0] wdata;
    } fsc_dev_req_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } fsc_dev_rsp_t;

endpackage

// >>> fsc_access.sv
// one access to the device: request held until ack, then a gap cycle
// assumes the device drops ack in the cycle after it gave it
`timescale 1ns/1ps
module fsc_access
    import fsc_pkg::*;
#(
    parameter int STALL_LIMIT = 2 * PROG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire fsc_dev_req_t cmd,
    output fsc_dev_req_t dev_req,
    input wire fsc_dev_rsp_t dev_rsp,
    output logic done,
    output logic [7:0] rdata,
    output logic overrun
);

    logic gap;
    logic [31:0] wait_cnt;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dev_req <= '0;
            done <= 1'b0;
            rdata <= 8'h00;
            gap <= 1'b0;
        end else begin
            done <= 1'b0;
            gap <= 1'b0;
            if (dev_req.req && dev_rsp.ack) begin
                dev_req.req <= 1'b0;
                rdata <= dev_rsp.rdata;
                done <= 1'b1;
                gap <= 1'b1;
            end else if (!dev_req.req && !gap && start) begin
                dev_req <= cmd;
                dev_req.req <= 1'b1;
            end
        end
    end

    // a stuck long write would hang the controller silently; flag it instead
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wait_cnt <= 32'h0000_0000;
            overrun <= 1'b0;
        end else if (!dev_req.req) begin
            wait_cnt <= 32'h0000_0000;
        end else begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
            if (wait_cnt == 32'(STALL_LIMIT)) begin
                overrun <= 1'b1;
            end
        end
    end

endmodule

// >>> fsc_controller.sv
// flash self-write controller: software loads a 64-byte row and a target address over
// wishbone, then the controller drives the device through erase, fill, unlock, program, verify
// assumes a device on the fsc_dev_req_t / fsc_dev_rsp_t link that stalls its ack during long writes
`timescale 1ns/1ps
module fsc_controller
    import fsc_pkg::*;
#(
    parameter int STALL_LIMIT = 2 * PROG_CYCLES,
    parameter int ROW_LEN = ROW_BYTES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output fsc_dev_req_t dev_req,
    input wire fsc_dev_rsp_t dev_rsp
);

    typedef enum {
        S_IDLE, S_PTR_U, S_PTR_H, S_PTR_L, S_FILL_LAT, S_FILL_TBL, S_ARM_CTL, S_IRQ_RD,
        S_IRQ_OFF, S_KEY1, S_KEY2, S_START, S_IRQ_ON, S_CTL_OFF, S_ERR_RD, S_VER_TBL,
        S_VER_LAT, S_DONE
    } fsc_state_t;

    typedef enum {
        FOR_ERASE, FOR_FILL, FOR_VERIFY
    } fsc_ptr_use_t;

    localparam logic [ROW_BITS-1:0] LAST_IDX = ROW_BITS'(ROW_LEN - 1);

    fsc_state_t state;
    fsc_ptr_use_t ptr_for;
    logic [7:0] row_buf [ROW_LEN];
    logic [ROW_BITS-1:0] buf_idx;
    logic [ROW_BITS-1:0] idx;
    logic [PTR_W-1:0] target;
    logic [3:0] cmd_bits;
    logic go;
    logic busy;
    logic done_flag;
    logic werr_flag;
    logic vfail_flag;
    logic [7:0] saved_irq;
    logic [7:0] last_ctl;
    logic acc_busy;
    logic acc_start;
    logic acc_done;
    logic acc_overrun;
    logic [7:0] acc_rdata;
    fsc_dev_req_t acc_cmd;
    logic [PTR_W-1:0] ptr_val;
    logic wb_req;
    logic wb_wr;
    logic erase_phase;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign erase_phase = (ptr_for == FOR_ERASE);

    // erase keeps the raw target since the device drops the low bits itself
    always_comb begin
        if (erase_phase) begin
            ptr_val = target;
        end else begin
            ptr_val = {target[PTR_W-1:ROW_BITS], ROW_BITS'(0)};
        end
    end

    // wishbone slave: one wait state, every address answered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    REG_CMD: wb_dat_o <= {28'h0000000, cmd_bits};
                    REG_ADDR: wb_dat_o <= {10'h000, target};
                    REG_BUF_IDX: wb_dat_o <= {26'h0000000, buf_idx};
                    REG_BUF_DATA: wb_dat_o <= {24'h000000, row_buf[buf_idx]};
                    REG_STATUS: begin
                        wb_dat_o[ST_BUSY_BIT] <= busy;
                        wb_dat_o[ST_DONE_BIT] <= done_flag;
                        wb_dat_o[ST_WERR_BIT] <= werr_flag;
                        wb_dat_o[ST_VFAIL_BIT] <= vfail_flag;
                        wb_dat_o[ST_OVERRUN_BIT] <= acc_overrun;
                        wb_dat_o[ST_ROW_LSB +: 4] <= target[BLOCK_BITS-1:ROW_BITS];
                        wb_dat_o[ST_CTL_LSB +: 8] <= last_ctl;
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // command register; a command while busy is dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_bits <= 4'h0;
            go <= 1'b0;
        end else begin
            go <= 1'b0;
            if (wb_wr && wb_adr_i == REG_CMD && !busy && !go) begin
                cmd_bits <= wb_dat_i[3:0];
                go <= wb_dat_i[CMD_PROGRAM_BIT] || wb_dat_i[CMD_ERASE_BIT];
            end
        end
    end

    // target address; advances one row after each good program so 16 refills cover a block
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            target <= '0;
        end else if (state == S_DONE && cmd_bits[CMD_PROGRAM_BIT] && !werr_flag) begin
            target <= target + PTR_W'(ROW_LEN);
        end else if (wb_wr && wb_adr_i == REG_ADDR && !busy) begin
            target <= wb_dat_i[PTR_W-1:0];
        end
    end

    // source row kept in flops; software writes are locked out while a sequence runs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            buf_idx <= '0;
        end else if (wb_wr && wb_adr_i == REG_BUF_IDX && !busy) begin
            buf_idx <= wb_dat_i[ROW_BITS-1:0];
        end else if (wb_wr && wb_adr_i == REG_BUF_DATA && !busy) begin
            buf_idx <= buf_idx + ROW_BITS'(1);
        end
    end

    for (genvar i = 0; i < ROW_LEN; i++) begin : g_row
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                row_buf[i] <= 8'h00;
            end else if (wb_wr && wb_adr_i == REG_BUF_DATA && !busy && buf_idx == ROW_BITS'(i)) begin
                row_buf[i] <= wb_dat_i[7:0];
            end
        end
    end

    // one device access per access state, issued on entry
    assign acc_start = !acc_busy && state != S_IDLE && state != S_DONE;

    always_comb begin
        acc_cmd = '0;
        acc_cmd.op = FSC_OP_REG_WR;
        acc_cmd.sel = FSC_SEL_WRITE_CTL;
        case (state)
            S_PTR_U: begin
                acc_cmd.sel = FSC_SEL_PTR_UPPER;
                acc_cmd.wdata = 8'(ptr_val[PTR_W-1:16]);
            end
            S_PTR_H: begin
                acc_cmd.sel = FSC_SEL_PTR_HIGH;
                acc_cmd.wdata = ptr_val[15:8];
            end
            S_PTR_L: begin
                acc_cmd.sel = FSC_SEL_PTR_LOW;
                acc_cmd.wdata = ptr_val[7:0];
            end
            S_FILL_LAT: begin
                acc_cmd.sel = FSC_SEL_BYTE_LATCH;
                acc_cmd.wdata = row_buf[idx];
            end
            S_FILL_TBL: begin
                // last byte leaves the pointer on the row's final byte
                acc_cmd.op = (idx == LAST_IDX) ? FSC_OP_TBL_WR : FSC_OP_TBL_WR_INC;
            end
            S_ARM_CTL: begin
                acc_cmd.wdata[CTL_WRITE_ENABLE_BIT_BIT] = 1'b1;
                acc_cmd.wdata[CTL_ERASE_BIT] = erase_phase;
            end
            S_IRQ_RD: begin
                acc_cmd.op = FSC_OP_REG_RD;
                acc_cmd.sel = FSC_SEL_IRQ_CTL;
            end
            S_IRQ_OFF: begin
                acc_cmd.sel = FSC_SEL_IRQ_CTL;
                acc_cmd.wdata = saved_irq;
                acc_cmd.wdata[IRQ_GLOBAL_BIT] = 1'b0;
            end
            S_KEY1: begin
                acc_cmd.sel = FSC_SEL_UNLOCK_KEY;
                acc_cmd.wdata = UNLOCK_KEY_1;
            end
            S_KEY2: begin
                acc_cmd.sel = FSC_SEL_UNLOCK_KEY;
                acc_cmd.wdata = UNLOCK_KEY_2;
            end
            S_START: begin
                acc_cmd.wdata[CTL_WRITE_ENABLE_BIT_BIT] = 1'b1;
                acc_cmd.wdata[CTL_ERASE_BIT] = erase_phase;
                acc_cmd.wdata[CTL_START_BIT] = 1'b1;
            end
            S_IRQ_ON: begin
                acc_cmd.sel = FSC_SEL_IRQ_CTL;
                acc_cmd.wdata = saved_irq;
            end
            S_CTL_OFF: begin
                acc_cmd.wdata = 8'h00;
            end
            S_ERR_RD: begin
                acc_cmd.op = FSC_OP_REG_RD;
            end
            S_VER_TBL: begin
                acc_cmd.op = FSC_OP_TBL_RD_INC;
            end
            S_VER_LAT: begin
                acc_cmd.op = FSC_OP_REG_RD;
                acc_cmd.sel = FSC_SEL_BYTE_LATCH;
            end
            default: begin
                acc_cmd.wdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_busy <= 1'b0;
        end else if (acc_done) begin
            acc_busy <= 1'b0;
        end else if (acc_start) begin
            acc_busy <= 1'b1;
        end
    end

    // sequence state; the unlock pair and start go out with nothing in between
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= S_IDLE;
            ptr_for <= FOR_FILL;
            idx <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (go) begin
                        idx <= '0;
                        state <= S_PTR_U;
                        if (cmd_bits[CMD_ERASE_BIT] || cmd_bits[CMD_ERASE_FIRST_BIT]) begin
                            ptr_for <= FOR_ERASE;
                        end else begin
                            ptr_for <= FOR_FILL;
                        end
                    end
                end
                S_PTR_U: if (acc_done) state <= S_PTR_H;
                S_PTR_H: if (acc_done) state <= S_PTR_L;
                S_PTR_L: begin
                    if (acc_done) begin
                        idx <= '0;
                        case (ptr_for)
                            FOR_ERASE: state <= S_ARM_CTL;
                            FOR_FILL: state <= S_FILL_LAT;
                            default: state <= S_VER_TBL;
                        endcase
                    end
                end
                S_FILL_LAT: if (acc_done) state <= S_FILL_TBL;
                S_FILL_TBL: begin
                    if (acc_done) begin
                        if (idx == LAST_IDX) begin
                            state <= S_ARM_CTL;
                        end else begin
                            idx <= idx + ROW_BITS'(1);
                            state <= S_FILL_LAT;
                        end
                    end
                end
                S_ARM_CTL: if (acc_done) state <= S_IRQ_RD;
                S_IRQ_RD: if (acc_done) state <= S_IRQ_OFF;
                S_IRQ_OFF: if (acc_done) state <= S_KEY1;
                S_KEY1: if (acc_done) state <= S_KEY2;
                S_KEY2: if (acc_done) state <= S_START;
                // ack comes back only after the device's timed long write ends
                S_START: if (acc_done) state <= S_IRQ_ON;
                S_IRQ_ON: if (acc_done) state <= S_CTL_OFF;
                S_CTL_OFF: if (acc_done) state <= S_ERR_RD;
                S_ERR_RD: begin
                    if (acc_done) begin
                        if (acc_rdata[CTL_ERROR_BIT]) begin
                            state <= S_DONE;
                        end else if (erase_phase && cmd_bits[CMD_PROGRAM_BIT]) begin
                            ptr_for <= FOR_FILL;
                            state <= S_PTR_U;
                        end else if (!erase_phase && cmd_bits[CMD_VERIFY_BIT]) begin
                            ptr_for <= FOR_VERIFY;
                            state <= S_PTR_U;
                        end else begin
                            state <= S_DONE;
                        end
                    end
                end
                S_VER_TBL: if (acc_done) state <= S_VER_LAT;
                S_VER_LAT: begin
                    if (acc_done) begin
                        if (idx == LAST_IDX) begin
                            state <= S_DONE;
                        end else begin
                            idx <= idx + ROW_BITS'(1);
                            state <= S_VER_TBL;
                        end
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            saved_irq <= 8'h00;
            last_ctl <= 8'h00;
        end else if (acc_done && state == S_IRQ_RD) begin
            saved_irq <= acc_rdata;
        end else if (acc_done && state == S_ERR_RD) begin
            last_ctl <= acc_rdata;
        end
    end

    // status flags; a new command clears them, which cannot meet a set since go waits for idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy <= 1'b0;
            done_flag <= 1'b0;
            werr_flag <= 1'b0;
            vfail_flag <= 1'b0;
        end else begin
            if (go) begin
                busy <= 1'b1;
                done_flag <= 1'b0;
                werr_flag <= 1'b0;
                vfail_flag <= 1'b0;
            end
            if (state == S_DONE) begin
                busy <= 1'b0;
                done_flag <= 1'b1;
            end
            if (acc_done && state == S_ERR_RD && acc_rdata[CTL_ERROR_BIT]) begin
                werr_flag <= 1'b1;
            end
            if (acc_done && state == S_VER_LAT && acc_rdata != row_buf[idx]) begin
                vfail_flag <= 1'b1;
            end
        end
    end

    fsc_access #(
        .STALL_LIMIT(STALL_LIMIT)
    ) u_access (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(acc_start),
        .cmd(acc_cmd),
        .dev_req(dev_req),
        .dev_rsp(dev_rsp),
        .done(acc_done),
        .rdata(acc_rdata),
        .overrun(acc_overrun)
    );

endmodule

// >>> fsc_controller_assertions.sv
// port checker for the flash self-write controller
// assumes a bind into fsc_controller; sees its ports only
`timescale 1ns/1ps
module fsc_ctl_checker
    import fsc_pkg::*;
#(
    parameter int ROW_LEN = ROW_BYTES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire fsc_dev_req_t dev_req,
    input wire fsc_dev_rsp_t dev_rsp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic xfer, wr, ctl_wr, go_wr;
    logic [1:0] keys;
    logic irq_off;
    int fill;
    assign xfer = dev_req.req && dev_rsp.ack;
    assign wr = xfer && dev_req.op == FSC_OP_REG_WR;
    assign ctl_wr = wr && dev_req.sel == FSC_SEL_WRITE_CTL;
    assign go_wr = ctl_wr && dev_req.wdata[CTL_START_BIT];
    // any other accepted access restarts the unlock count
    always_ff @(posedge ref_clk) begin
        if (rst)
            keys <= 2'd0;
        else if (wr && dev_req.sel == FSC_SEL_UNLOCK_KEY && dev_req.wdata == UNLOCK_KEY_1)
            keys <= 2'd1;
        else if (wr && dev_req.sel == FSC_SEL_UNLOCK_KEY && dev_req.wdata == UNLOCK_KEY_2 && keys == 2'd1)
            keys <= 2'd2;
        else if (xfer)
            keys <= 2'd0;
    end
    always_ff @(posedge ref_clk) begin
        if (rst)
            irq_off <= 1'b0;
        else if (wr && dev_req.sel == FSC_SEL_IRQ_CTL)
            irq_off <= !dev_req.wdata[IRQ_GLOBAL_BIT];
    end
    always_ff @(posedge ref_clk) begin
        if (rst || (wr && dev_req.sel == FSC_SEL_PTR_LOW))
            fill <= 0;
        else if (xfer && (dev_req.op == FSC_OP_TBL_WR || dev_req.op == FSC_OP_TBL_WR_INC))
            fill <= fill + 1;
    end
    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_wb_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    a_req_hold: assert property (dev_req.req && !dev_rsp.ack |=> dev_req.req && $stable(dev_req))
        else $error("request moved");
    a_req_release: assert property (xfer |=> !dev_req.req) else $error("request held");
    a_unlock_pair: assert property (go_wr |-> keys == 2'd2 && irq_off) else $error("start not unlocked");
    a_start_write_enable_bit: assert property (go_wr |-> dev_req.wdata[CTL_WRITE_ENABLE_BIT_BIT]) else $error("no enable at start");
    a_row_fill: assert property (go_wr && !dev_req.wdata[CTL_ERASE_BIT] |-> fill == ROW_LEN)
        else $error("row not full");
    a_write_enable_bit_drop: assert property (go_wr |-> ##[1:60] ctl_wr && !dev_req.wdata[CTL_WRITE_ENABLE_BIT_BIT])
        else $error("enable left set");
    c_program: cover property (go_wr && !dev_req.wdata[CTL_ERASE_BIT]);
    c_erase: cover property (go_wr && dev_req.wdata[CTL_ERASE_BIT]);
    c_wb: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule

// >>> fsc_dev_model.sv
// device model: pointer, holding row, unlock key, timed long write, flash
// assumes one request at a time held until ack; acks after a varying latency
`timescale 1ns/1ps
module fsc_dev_model
    import fsc_pkg::*;
#(
    parameter int STALL = 300,
    parameter logic [7:0] ERASED = 8'hff,
    parameter logic [7:0] IRQ_RESET = 8'h80
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire fsc_dev_req_t dev_req,
    output fsc_dev_rsp_t dev_rsp,
    input wire logic [1:0] fault
);
    logic [7:0] flash [int];
    logic [7:0] hold [ROW_BYTES];
    logic [21:0] ptr;
    logic [7:0] latch, irq, ctl, rd;
    logic key1, armed, g;
    int cnt, pace;
    wire logic go = dev_req.op == FSC_OP_REG_WR && dev_req.sel == FSC_SEL_WRITE_CTL && armed
        && dev_req.wdata[CTL_START_BIT] && dev_req.wdata[CTL_WRITE_ENABLE_BIT_BIT] && ctl[CTL_WRITE_ENABLE_BIT_BIT];
    function automatic logic [7:0] peek(input int a);
        return flash.exists(a) ? flash[a] : ERASED;
    endfunction
    // fault 1: reset-like abort, error flag sticks; fault 2: byte 5 corrupted
    task long_write();
        int base;
        armed = 1'b0;
        if (fault == 2'd1) begin
            ctl[CTL_ERROR_BIT] = 1'b1;
        end else if (ctl[CTL_ERASE_BIT]) begin
            base = int'({ptr[21:10], 10'h000});
            for (int i = 0; i < 1024; i++) flash[base + i] = ERASED;
        end else begin
            base = int'({ptr[21:6], 6'h00});
            for (int i = 0; i < ROW_BYTES; i++) flash[base + i] = hold[i] ^ {7'h00, fault == 2'd2 && i == 5};
        end
    endtask
    task access();
        g = go;
        if (!(dev_req.op == FSC_OP_REG_WR && dev_req.sel == FSC_SEL_UNLOCK_KEY) && !g) begin
            key1 = 1'b0;
            armed = 1'b0;
        end
        case (dev_req.op)
            FSC_OP_TBL_WR, FSC_OP_TBL_WR_INC: begin
                hold[ptr[5:0]] = latch;
                if (dev_req.op == FSC_OP_TBL_WR_INC) ptr++;
            end
            FSC_OP_TBL_RD_INC: begin
                latch = peek(int'(ptr));
                ptr++;
            end
            FSC_OP_REG_RD: case (dev_req.sel)
                FSC_SEL_PTR_UPPER: rd = {2'b00, ptr[21:16]};
                FSC_SEL_PTR_HIGH: rd = ptr[15:8];
                FSC_SEL_PTR_LOW: rd = ptr[7:0];
                FSC_SEL_BYTE_LATCH: rd = latch;
                FSC_SEL_IRQ_CTL: rd = irq;
                FSC_SEL_WRITE_CTL: rd = ctl;
                default: rd = 8'h00;
            endcase
            default: case (dev_req.sel)
                FSC_SEL_PTR_UPPER: ptr[21:16] = dev_req.wdata[5:0];
                FSC_SEL_PTR_HIGH: ptr[15:8] = dev_req.wdata;
                FSC_SEL_PTR_LOW: ptr[7:0] = dev_req.wdata;
                FSC_SEL_BYTE_LATCH: latch = dev_req.wdata;
                FSC_SEL_IRQ_CTL: irq = dev_req.wdata;
                FSC_SEL_UNLOCK_KEY: begin
                    armed = key1 && dev_req.wdata == UNLOCK_KEY_2;
                    key1 = dev_req.wdata == UNLOCK_KEY_1;
                end
                default: begin
                    ctl = {3'b000, dev_req.wdata[4], ctl[3], dev_req.wdata[2], 2'b00};
                    if (g) long_write();
                end
            endcase
        endcase
    endtask
    initial dev_rsp = '0;
    always @(posedge ref_clk) begin
        dev_rsp.ack <= 1'b0;
        dev_rsp.rdata <= ~dev_rsp.rdata; // idle data toggles so stale bytes never look valid
        if (rst) begin
            ptr = '0;
            latch = 8'h00;
            irq = IRQ_RESET;
            ctl = 8'h00;
            key1 = 1'b0;
            armed = 1'b0;
            cnt = 0;
            pace = 0;
            dev_rsp.rdata <= 8'h00;
        end else if (dev_req.req && !dev_rsp.ack) begin
            if (cnt < (go ? STALL : pace % 4)) begin
                cnt++;
            end else begin
                cnt = 0;
                pace++;
                rd = 8'h00;
                access();
                dev_rsp.ack <= 1'b1;
                dev_rsp.rdata <= rd;
            end
        end
    end
endmodule

// >>> tb_top.sv
// bench: wishbone master, controller, device model, verdict
// assumes the checker and model files compile first
`timescale 1ns/1ps
module tb_top
    import fsc_pkg::*;
;
    logic ref_clk, rst, cyc, stb, we, wb_ack_o;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, wb_dat_o;
    logic [1:0] fault;
    fsc_dev_req_t dev_req;
    fsc_dev_rsp_t dev_rsp;
    int fails, checked;
    fsc_controller #(.STALL_LIMIT(2000)) dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .dev_req(dev_req), .dev_rsp(dev_rsp));
    fsc_dev_model dev_u (.ref_clk(ref_clk), .rst(rst), .dev_req(dev_req), .dev_rsp(dev_rsp), .fault(fault));
    function automatic logic [7:0] pat(input int i, input logic [7:0] k);
        return 8'(i * 7) ^ k;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rdat = wb_dat_o;
        if (n >= 50) fails++;
        {cyc, stb, we} <= 3'b000;
        @(posedge ref_clk);
    endtask
    task automatic fill(input logic [7:0] k);
        wb(1'b1, REG_BUF_IDX, 32'h0);
        for (int i = 0; i < ROW_BYTES; i++) wb(1'b1, REG_BUF_DATA, {24'h0, pat(i, k)});
    endtask
    // the address write while busy must be ignored
    task automatic run(input logic [21:0] a, input logic [3:0] cmd);
        int n = 0;
        wb(1'b1, REG_ADDR, {10'h0, a});
        wb(1'b1, REG_CMD, {28'h0, cmd});
        wb(1'b1, REG_ADDR, 32'h3fffff);
        do begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rdat[ST_BUSY_BIT] !== 1'b0 && n < 3000);
        if (n >= 3000) fails++;
    endtask
    task automatic rows(input int base, input logic [7:0] k);
        for (int i = 0; i < ROW_BYTES; i++) check("flash byte", dev_u.peek(base + i), pat(i, k));
    endtask
    task results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        results();
    end
    initial begin
        {rst, cyc, stb, we, adr, sel, wdat, fault} = {1'b1, 3'b000, 8'h00, 4'hf, 32'h0, 2'd0};
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        wb(1'b0, REG_STATUS, 32'h0);
        check("reset status", rdat, 32'h0);
        wb(1'b1, 8'h3c, 32'h12345678);
        wb(1'b0, 8'h3c, 32'h0);
        check("unmapped read", rdat, 32'h0);
        fill(8'h5a);
        run(22'h012345, 4'h9);
        check("program status", rdat & 32'h00ff001f, 32'h2);
        rows(32'h12340, 8'h5a);
        wb(1'b0, REG_ADDR, 32'h0);
        check("next row", rdat, 32'h12385);
        run(22'h012345, 4'h2);
        check("erase status", rdat & 32'h00ff001f, 32'h2);
        check("erased row", dev_u.peek(32'h12340), 32'hff);
        check("block start", dev_u.peek(32'h12000), 32'hff);
        wb(1'b0, REG_ADDR, 32'h0);
        check("erase address", rdat, 32'h12345);
        fill(8'hc3);
        run(22'h0123c0, 4'h5);
        check("erase program", rdat & 32'h1f, 32'h02);
        rows(32'h123c0, 8'hc3);
        fault <= 2'd2;
        run(22'h012400, 4'h9);
        check("verify failure", rdat & 32'h0d, 32'h08);
        fault <= 2'd1;
        run(22'h012800, 4'h1);
        check("aborted write", rdat & 32'h0d, 32'h04);
        check("aborted row", dev_u.peek(32'h12800), 32'hff);
        results();
    end
endmodule
bind fsc_controller fsc_ctl_checker #(.ROW_LEN(ROW_LEN)) chk_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_req(dev_req), .dev_rsp(dev_rsp));
